// File: logic/usbnd_top.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module usbnd_top
  import usbnd_pkg::*;
(
  // Clock, reset and enable.
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  // APB slave.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Bus line state and decoded token.
  input wire logic [1:0] I_LINE,
  input wire logic I_EOP,
  input wire logic I_TOKEN_VALID,
  input wire logic I_TOKEN_IN,
  input wire logic [6:0] I_TOKEN_ADDR,
  input wire logic [3:0] I_TOKEN_EP,
  // Bus drive and FIFO select.
  output logic O_DRIVE_K,
  output logic O_SEL_VALID,
  output logic [6:0] O_SEL_FIFO,
  output logic [1:0] O_NODE_STATE
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  usbnd_state_t node_state;
  logic [EV_W-1:0] alt_event;
  logic [6:0] func_addr;
  logic [9:0] ep_ctrl [NUM_EP];
  logic [TMR_W-1:0] idle_cnt;
  logic idle3_done;
  logic idle5_done;
  logic [1:0] line_prev;
  logic [EV_W-1:0] ev_set;
  logic [6:0] next_sel;
  logic acc_wr;
  logic [7:0] token_idx;

  assign acc_wr = I_PSEL & I_PENABLE & I_PWRITE;

  // Endpoint register index from a byte address; NUM_EP means none.
  function automatic logic [EP_IDX_W-1:0] ep_index(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - OFS_EP_BASE;
    if (addr >= OFS_EP_BASE && addr <= OFS_EP_LAST && d[1:0] == 2'b00) begin
      ep_index = d[EP_IDX_W+1:2];
    end else begin
      ep_index = EP_IDX_W'(NUM_EP);
    end
  endfunction

  // True when the slot is a transmit FIFO; slot 0 serves both directions.
  function automatic logic is_tx_slot(input int slot);
    is_tx_slot = (slot % 2) == 1;
  endfunction

  // ---------------------------------------------------------------------------
  // Line condition detection
  // ---------------------------------------------------------------------------
  // Events are computed from the line; they never touch the node state.
  always_comb begin
    ev_set = '0;
    ev_set[EV_IDLE3] = idle_cnt == TMR_W'(IDLE3_CYC - 1) && !idle3_done;
    ev_set[EV_IDLE5] = idle_cnt == TMR_W'(IDLE5_CYC - 1) && !idle5_done;
    // A K after idle means resume signalling from the host.
    ev_set[EV_RESUME] = I_LINE == LINE_K && line_prev == LINE_J && idle3_done;
    ev_set[EV_RESET] = I_LINE == LINE_SE0 && line_prev != LINE_SE0 && !I_EOP;
    ev_set[EV_EOP] = I_EOP && node_state == NODE_RUNNING_STATE;
  end

  // Idle timer; it saturates so each idle flag rises once per quiet period.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      idle_cnt <= '0;
      idle3_done <= 1'b0;
      idle5_done <= 1'b0;
      line_prev <= LINE_J;
    end else if (I_CE) begin
      line_prev <= I_LINE;
      if (I_LINE != LINE_J) begin
        idle_cnt <= '0;
        idle3_done <= 1'b0;
        idle5_done <= 1'b0;
      end else begin
        if (idle_cnt != TMR_W'(IDLE5_CYC - 1)) begin
          idle_cnt <= idle_cnt + 1'b1;
        end
        if (ev_set[EV_IDLE3]) begin
          idle3_done <= 1'b1;
        end
        if (ev_set[EV_IDLE5]) begin
          idle5_done <= 1'b1;
        end
      end
    end
  end

  // Alternate events: write one to clear; a new event wins over the clear.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      alt_event <= '0;
    end else if (I_CE) begin
      if (acc_wr && I_PADDR == OFS_ALT_EVENT) begin
        alt_event <= (alt_event & ~I_PWDATA[EV_W-1:0]) | ev_set;
      end else begin
        alt_event <= alt_event | ev_set;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Node state and configuration registers
  // ---------------------------------------------------------------------------
  // The state moves only on a firmware write, never on detection.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      node_state <= BUS_RESET_STATE;
    end else if (I_CE && acc_wr && I_PADDR == OFS_NODE_STATE) begin
      node_state <= usbnd_state_t'(I_PWDATA[1:0]);
    end
  end

  // Function address is frozen outside the running state.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      func_addr <= '0;
    end else if (I_CE && acc_wr && I_PADDR == OFS_FUNC_ADDR
                 && node_state == NODE_RUNNING_STATE) begin
      func_addr <= I_PWDATA[6:0];
    end
  end

  // Endpoint controls: arm, last and full bits drop whenever the node is not running.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      for (int i = 0; i < NUM_EP; i++) begin
        ep_ctrl[i] <= EPC_RESET;
      end
    end else if (I_CE) begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (node_state != NODE_RUNNING_STATE) begin
          ep_ctrl[i][EPC_TXARM_BIT] <= 1'b0;
          ep_ctrl[i][EPC_LAST_BIT] <= 1'b0;
          ep_ctrl[i][EPC_RXARM_BIT] <= 1'b0;
          ep_ctrl[i][EPC_FULL_BIT] <= 1'b0;
        end else if (acc_wr && ep_index(I_PADDR) == EP_IDX_W'(i)) begin
          ep_ctrl[i] <= I_PWDATA[9:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Address and endpoint decode
  // ---------------------------------------------------------------------------
  // All seven endpoint numbers are compared at once after an address match.
  always_comb begin
    next_sel = '0;
    if (I_TOKEN_VALID && I_TOKEN_ADDR == func_addr
        && node_state == NODE_RUNNING_STATE) begin
      for (int i = NUM_EP - 1; i >= 0; i--) begin
        // Direction filter keeps opposite directions apart.
        if (ep_ctrl[i][EPC_EN_BIT] && ep_ctrl[i][3:0] == I_TOKEN_EP
            && (i == 0 || is_tx_slot(i) == I_TOKEN_IN)
            && !(ep_ctrl[i][EPC_ISO_BIT] && ep_ctrl[i][EPC_FULL_BIT])) begin
          // Descending scan leaves the lowest match as the winner.
          next_sel = 7'(1 << i);
        end
      end
    end
  end

  // Registered FIFO select; an ISO slot is skipped while firmware has its full bit set.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_SEL_FIFO <= '0;
      O_SEL_VALID <= 1'b0;
    end else if (I_CE) begin
      O_SEL_FIFO <= next_sel;
      O_SEL_VALID <= next_sel != '0;
    end
  end

  // Token capture for readback.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      token_idx <= NO_MATCH;
    end else if (I_CE && I_TOKEN_VALID) begin
      token_idx <= {1'b0, next_sel};
    end
  end

  // ---------------------------------------------------------------------------
  // Bus drive and APB response
  // ---------------------------------------------------------------------------
  // K is driven for as long as the resume state stands.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_DRIVE_K <= 1'b0;
      O_NODE_STATE <= BUS_RESET_STATE;
    end else if (I_CE) begin
      O_DRIVE_K <= node_state == NODE_WAKE_SIGNAL_STATE;
      O_NODE_STATE <= node_state;
    end
  end

  // Zero-wait slave: pready is registered from the setup cycle, so it is high in the first access cycle.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_PRDATA <= '0;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else if (I_CE) begin
      O_PREADY <= I_PSEL & ~I_PENABLE;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= '0;
      if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
        if (I_PADDR == OFS_NODE_STATE) begin
          O_PRDATA <= {30'h0000_0000, node_state};
        end else if (I_PADDR == OFS_ALT_EVENT) begin
          O_PRDATA <= {27'h000_0000, alt_event};
        end else if (I_PADDR == OFS_FUNC_ADDR) begin
          O_PRDATA <= {25'h000_0000, func_addr};
        end else if (I_PADDR == OFS_TOKEN) begin
          O_PRDATA <= {24'h00_0000, token_idx};
        end else if (ep_index(I_PADDR) != EP_IDX_W'(NUM_EP)) begin
          O_PRDATA <= {22'h00_0000, ep_ctrl[ep_index(I_PADDR)]};
        end
      end
    end
  end

endmodule

// File: logic/usbnd_pkg.sv
package usbnd_pkg;

  // ---------------------------------------------------------------------------
  // Clock and line timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int IDLE3_MS = 3;
  localparam int IDLE5_MS = 5;
  // Cycle counts derived from the printed milliseconds and the clock rate.
  localparam int IDLE3_CYC = IDLE3_MS * 1000 * CLK_MHZ;
  localparam int IDLE5_CYC = IDLE5_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 24;

  // ---------------------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_NODE_STATE = 8'h00;
  localparam logic [7:0] OFS_ALT_EVENT = 8'h04;
  localparam logic [7:0] OFS_FUNC_ADDR = 8'h08;
  localparam logic [7:0] OFS_EP_BASE = 8'h10;
  localparam logic [7:0] OFS_EP_LAST = 8'h28;
  localparam logic [7:0] OFS_TOKEN = 8'h30;

  localparam int NUM_EP = 7;
  localparam int EP_IDX_W = 3;

  // Endpoint control fields.
  localparam int EPC_NUM_LSB = 0;
  localparam int EPC_EN_BIT = 4;
  localparam int EPC_ISO_BIT = 5;
  localparam int EPC_TXARM_BIT = 6;
  localparam int EPC_LAST_BIT = 7;
  localparam int EPC_RXARM_BIT = 8;
  localparam int EPC_FULL_BIT = 9;
  localparam logic [9:0] EPC_RESET = 10'h000;

  // Alternate event bits.
  localparam int EV_IDLE3 = 0;
  localparam int EV_IDLE5 = 1;
  localparam int EV_RESUME = 2;
  localparam int EV_RESET = 3;
  localparam int EV_EOP = 4;
  localparam int EV_W = 5;

  // Node state field encodings.
  typedef enum logic [1:0] {
    BUS_RESET_STATE = 2'b00,
    NODE_WAKE_SIGNAL_STATE = 2'b01,
    NODE_RUNNING_STATE = 2'b10,
    NODE_SLEEP_STATE = 2'b11
  } usbnd_state_t;

  // Line states on the bus.
  localparam logic [1:0] LINE_SE0 = 2'b00;
  localparam logic [1:0] LINE_J = 2'b01;
  localparam logic [1:0] LINE_K = 2'b10;

  // FIFO depths in bytes, and the no-match token index.
  localparam int CTRL_FIFO_BYTES = 8;
  localparam int EP_FIFO_BYTES = 64;
  localparam logic [7:0] NO_MATCH = 8'h00;

endpackage

// File: sim/usbnd_host_model.sv
`timescale 1ns/1ps
// Far-end host: drives line state and decoded tokens.
module usbnd_host_model
  import usbnd_pkg::*;
(
  input wire logic clk,
  output logic [1:0] line,
  output logic eop,
  output logic tv,
  output logic tin,
  output logic [6:0] ta,
  output logic [3:0] te
);
  // Idle bus is J; no token pending.
  initial begin
    line = LINE_J;
    eop = 1'b0;
    tv = 1'b0;
    tin = 1'b0;
    ta = 7'h00;
    te = 4'h0;
  end
  // One-cycle token; fields inverted after so stale values never match.
  task automatic send_token(input logic d, input logic [6:0] a, input logic [3:0] e);
    @(posedge clk);
    tv <= 1'b1;
    tin <= d;
    ta <= a;
    te <= e;
    @(posedge clk);
    tv <= 1'b0;
    tin <= ~d;
    ta <= ~a;
    te <= ~e;
  endtask
  // Bus reset: SE0 without an end of packet, then J again.
  task automatic bus_reset();
    @(posedge clk);
    line <= LINE_SE0;
    repeat (20) @(posedge clk);
    line <= LINE_J;
  endtask
endmodule

// File: sim/usbnd_top_asserts.sv
`timescale 1ns/1ps
// Port-level checks; frozen cycles are skipped since nothing may move then.
module usbnd_top_asserts
  import usbnd_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic I_TOKEN_VALID,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_DRIVE_K,
  input wire logic O_SEL_VALID,
  input wire logic [6:0] O_SEL_FIFO,
  input wire logic [1:0] O_NODE_STATE
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET || !I_CE);
  a_pready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("no ready after setup");
  a_pready_in_access: assert property (O_PREADY |-> I_PSEL && I_PENABLE
    && $past(I_PSEL && !I_PENABLE)) else $error("stray ready");
  a_slverr_low: assert property (!O_PSLVERR) else $error("error response");
  a_state_by_write: assert property ($changed(O_NODE_STATE) |->
    $past(I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == OFS_NODE_STATE, 1)
    || $past(I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == OFS_NODE_STATE, 2))
    else $error("state moved without a write");
  // Both outputs are registered from the same state, so they move on one edge.
  a_drive_k_on: assert property (O_NODE_STATE == 2'b01 |-> O_DRIVE_K)
    else $error("no K in resume");
  a_drive_k_cause: assert property (O_DRIVE_K |-> O_NODE_STATE == 2'b01)
    else $error("K outside resume");
  a_sel_cause: assert property (O_SEL_VALID |-> $past(I_TOKEN_VALID))
    else $error("select without token");
  a_sel_one_fifo: assert property (O_SEL_VALID |-> $onehot(O_SEL_FIFO))
    else $error("select not one fifo");
endmodule
bind usbnd_top usbnd_top_asserts usbnd_top_asserts_inst (.I_REF_CLK, .I_RESET, .I_CE,
  .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_TOKEN_VALID, .O_PREADY, .O_PSLVERR,
  .O_DRIVE_K, .O_SEL_VALID, .O_SEL_FIFO, .O_NODE_STATE);

// File: sim/usb_node_state_and_endpoint_decode_tb.sv
`timescale 1ns/1ps
module usb_node_state_and_endpoint_decode_tb
  import usbnd_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, slverr, drive_k, sel_valid, eop, tv, tin;
  logic [6:0] sel_fifo, ta;
  logic [3:0] te;
  logic [1:0] line, node_state;
  logic [1:0] seq [4] = '{2'b00, 2'b11, 2'b01, 2'b10};
  int err_count = 0, checked = 0;
  // 250 MHz clock.
  always #2 clk = ~clk;
  usbnd_top usbnd_top_inst (.I_REF_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(slverr), .I_LINE(line), .I_EOP(eop),
    .I_TOKEN_VALID(tv), .I_TOKEN_IN(tin), .I_TOKEN_ADDR(ta), .I_TOKEN_EP(te),
    .O_DRIVE_K(drive_k), .O_SEL_VALID(sel_valid), .O_SEL_FIFO(sel_fifo),
    .O_NODE_STATE(node_state));
  usbnd_host_model usbnd_host_model_inst (.clk(clk), .line(line), .eop(eop), .tv(tv),
    .tin(tin), .ta(ta), .te(te));
  task automatic tally_and_finish();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // One APB transfer; an idle edge first keeps two transfers from colliding.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask
  function automatic logic [7:0] epa(input logic [2:0] i);
    return OFS_EP_BASE + {3'b000, i, 2'b00};
  endfunction
  // Token, then the select just after the edge that takes it.
  task automatic tok(input logic d, input logic [6:0] a, input logic [3:0] e,
                     input logic [7:0] x);
    usbnd_host_model_inst.send_token(d, a, e);
    #1;
    chk({24'h00_0000, sel_valid, sel_fifo}, {24'h00_0000, x});
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_NODE_STATE, 32'h0000_0000);
    foreach (seq[i]) begin
      wr(OFS_NODE_STATE, {30'h0000_0000, seq[i]});
      rd_chk(OFS_NODE_STATE, {30'h0000_0000, seq[i]});
      chk({30'h0000_0000, node_state}, {30'h0000_0000, seq[i]});
      chk({31'h0000_0000, drive_k}, {31'h0000_0000, seq[i] == 2'b01});
    end
    usbnd_host_model_inst.bus_reset();
    rd_chk(OFS_ALT_EVENT, 32'h0000_0008);
    rd_chk(OFS_NODE_STATE, 32'h0000_0002);
    wr(OFS_ALT_EVENT, 32'h0000_0008);
    rd_chk(OFS_ALT_EVENT, 32'h0000_0000);
    wr(OFS_NODE_STATE, 32'h0000_0000);
    wr(OFS_NODE_STATE, 32'h0000_0002);
    // Arm and last bits must drop in suspend while the rest holds.
    wr(epa(3'd1), 32'h0000_00D1);
    rd_chk(epa(3'd1), 32'h0000_00D1);
    wr(OFS_NODE_STATE, 32'h0000_0003);
    rd_chk(epa(3'd1), 32'h0000_0011);
    wr(OFS_NODE_STATE, 32'h0000_0002);
    wr(OFS_FUNC_ADDR, 32'h0000_0005);
    wr(epa(3'd0), 32'h0000_0010);
    wr(epa(3'd2), 32'h0000_0011);
    wr(epa(3'd3), 32'h0000_0011);
    wr(epa(3'd6), 32'h0000_0012);
    tok(1'b1, 7'h05, 4'h0, 8'h81);
    tok(1'b1, 7'h05, 4'h1, 8'h82);
    tok(1'b0, 7'h05, 4'h1, 8'h84);
    tok(1'b1, 7'h06, 4'h1, 8'h00);
    tok(1'b1, 7'h05, 4'h7, 8'h00);
    tok(1'b0, 7'h05, 4'h2, 8'hC0);
    tok(1'b1, 7'h05, 4'h2, 8'h00);
    wr(epa(3'd1), 32'h0000_0001);
    tok(1'b1, 7'h05, 4'h1, 8'h88);
    tok(1'b0, 7'h05, 4'h0, 8'h81);
    rd_chk(OFS_TOKEN, 32'h0000_0001);
    rd_chk(8'h3C, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
